// >>> hw/four_channel_pulse_counter.sv
// Behaviour
// R01: four independent ports, up to 500 kHz each
// R02: diff 1x/2x/4x, up/down, pulse/direction modes
// R03: match or in-range loads pattern into outputs
// R04: own pattern per comparison result
// R05: up to four external output lines
// R06: no counter interrupts from comparisons
// R07: ready indicator while pulses are accepted
// R08: per-port indicators follow a, b, z
// R09: one indicator per external output line
// R10: error on bad setup or count wrap
// R11: external lines are OR of four patterns
// R12: quadrature direction and edge multiplication
`include "four_channel_pulse_counter_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module four_channel_pulse_counter (
  input wire logic pclk, // apb clock, 25 MHz
  input wire logic presetn, // async reset, low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [3:0] pstrb, // apb byte strobes
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire four_channel_pulse_counter_pkg::phase_in_type [3:0] port_in, // pins
  output logic [3:0] compare_output_line, // external lines 4..1
  output four_channel_pulse_counter_pkg::led_type leds, // indicators
  output logic irq // error event interrupt
);
  four_channel_pulse_counter_pkg::top_state_type st_r, st_nxt;
  four_channel_pulse_counter_pkg::step_type [3:0] step; // decoder steps
  logic [3:0][3:0] pattern; // per-port compare patterns
  logic [3:0] cfg_bad; // invalid port setup
  logic [3:0] port_en; // port may count
  logic [3:0] ovf; // wrap past max
  logic [3:0] udf; // wrap below zero
  logic setup; // apb setup phase
  logic wr; // apb write commits now
  logic [3:0] grp; // address group
  logic [1:0] pidx; // address port

  // byte-lane merge of a write into a word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int k = 0; k < 4; k++) begin
      if (strb[k]) begin
        r[k*8 +: 8] = wd[k*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // true when the address hits a register
  function automatic logic mapped(input logic [7:0] a);
    logic r;
    r = 1'b0;
    if (a[1:0] == 2'b00) begin
      unique case (a[7:4])
        `PC_GRP_MISC: begin
          r = 1'b1;
        end
        `PC_GRP_OUTS: begin
          r = (a == `PC_ADDR_OUT_BITS);
        end
        `PC_GRP_PCFG, `PC_GRP_COUNT, `PC_GRP_TARGET,
        `PC_GRP_LO, `PC_GRP_HI, `PC_GRP_PAT: begin
          r = 1'b1;
        end
        default: begin
          r = 1'b0;
        end
      endcase
    end
    return r;
  endfunction : mapped

  // setup check of one port config word
  function automatic logic bad_cfg(input logic [4:0] c);
    logic [1:0] m;
    logic [1:0] x;
    m = c[`PC_CFG_MODE_LSB +: 2];
    x = c[`PC_CFG_MULT_LSB +: 2];
    return (m == four_channel_pulse_counter_pkg::MODE_BAD) ||
           (m == four_channel_pulse_counter_pkg::MODE_DIFF &&
            x == four_channel_pulse_counter_pkg::MULT_BAD);
  endfunction : bad_cfg

  // read mux for one address
  function automatic logic [31:0] rd_word(
      input four_channel_pulse_counter_pkg::top_state_type s,
      input logic [7:0] a);
    logic [31:0] r;
    r = `PC_WORD_RST;
    unique case (a[7:4])
      `PC_GRP_MISC: begin
        unique case (a)
          `PC_ADDR_CTRL: r[0] = s.enable;
          `PC_ADDR_STATUS: begin
            r[`PC_ST_READY] = s.led.ready;
            r[`PC_ST_ERR] = s.led.err;
            r[`PC_ST_OUT_LSB +: 4] = s.out_line;
          end
          `PC_ADDR_IRQ_STAT: r[8:0] = s.irq_st;
          `PC_ADDR_IRQ_MASK: r[8:0] = s.irq_mask;
          default: r = `PC_WORD_RST;
        endcase
      end
      `PC_GRP_OUTS: r[15:0] = s.int_bits;
      `PC_GRP_PCFG: r[4:0] = s.pcfg[a[3:2]];
      `PC_GRP_COUNT: r = s.count[a[3:2]];
      `PC_GRP_TARGET: r = s.target[a[3:2]];
      `PC_GRP_LO: r = s.lo[a[3:2]];
      `PC_GRP_HI: r = s.hi[a[3:2]];
      `PC_GRP_PAT: r[7:0] = s.pat[a[3:2]];
      default: r = `PC_WORD_RST;
    endcase
    return r;
  endfunction : rd_word

  // one decoder and one comparator per port
  for (genvar i = 0; i < 4; i++) begin : g_port
    pulse_step_decoder u_dec (
      .pclk(pclk),
      .presetn(presetn),
      .pins(port_in[i]),
      .mode(st_r.pcfg[i][`PC_CFG_MODE_LSB +: 2]),
      .mult(st_r.pcfg[i][`PC_CFG_MULT_LSB +: 2]),
      .enable(port_en[i]),
      .step(step[i])
    );
    compare_pattern u_cmp (
      .count(st_r.count[i]),
      .target(st_r.target[i]),
      .lo(st_r.lo[i]),
      .hi(st_r.hi[i]),
      .tgt_pat(st_r.pat[i][`PC_PAT_TGT_LSB +: 4]),
      .rng_pat(st_r.pat[i][`PC_PAT_RNG_LSB +: 4]),
      .en(st_r.pcfg[i][`PC_CFG_CMP_EN]),
      .pattern(pattern[i])
    );
  end

  // per-port validity and counting permission
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      cfg_bad[i] = bad_cfg(st_r.pcfg[i]); // see R10
      port_en[i] = st_r.enable & ~cfg_bad[i]; // see R01
    end
  end

  // next-state logic
  always_comb begin
    st_nxt = st_r;
    setup = psel & ~penable;
    wr = psel & penable & st_r.pready & pwrite & ~st_r.pslverr;
    grp = paddr[7:4];
    pidx = paddr[3:2];
    ovf = 4'h0;
    udf = 4'h0;
    // apb: ready in the cycle after setup, data fetched at setup
    st_nxt.pready = setup;
    st_nxt.pslverr = setup & ~mapped(paddr);
    st_nxt.prdata = setup ? rd_word(st_r, paddr) : `PC_WORD_RST;
    // counters, each port on its own
    for (int i = 0; i < 4; i++) begin
      if (step[i].up) begin // see R01
        if (st_r.count[i] == `PC_COUNT_MAX) begin
          ovf[i] = 1'b1; // see R10
        end
        st_nxt.count[i] = st_r.count[i] + `PC_COUNT_ONE;
      end else if (step[i].dn) begin
        if (st_r.count[i] == `PC_WORD_RST) begin
          udf[i] = 1'b1; // see R10
        end
        st_nxt.count[i] = st_r.count[i] - `PC_COUNT_ONE;
      end
    end
    // register writes, taken at the access edge
    if (wr) begin
      unique case (grp)
        `PC_GRP_MISC: begin
          if (paddr == `PC_ADDR_CTRL && pstrb[0]) begin
            st_nxt.enable = pwdata[0];
          end
          if (paddr == `PC_ADDR_IRQ_MASK) begin
            st_nxt.irq_mask = 9'(merge(32'(st_r.irq_mask), pwdata,
                                       pstrb));
          end
          if (paddr == `PC_ADDR_IRQ_STAT) begin
            // write one to clear
            st_nxt.irq_st = st_r.irq_st &
                            ~9'(merge(`PC_WORD_RST, pwdata, pstrb));
          end
        end
        `PC_GRP_PCFG: begin
          st_nxt.pcfg[pidx] = 5'(merge(32'(st_r.pcfg[pidx]), pwdata,
                                       pstrb));
        end
        `PC_GRP_COUNT: begin
          // a preset overrides a step in the same cycle
          st_nxt.count[pidx] = merge(st_r.count[pidx], pwdata, pstrb);
        end
        `PC_GRP_TARGET: begin
          st_nxt.target[pidx] = merge(st_r.target[pidx], pwdata, pstrb);
        end
        `PC_GRP_LO: begin
          st_nxt.lo[pidx] = merge(st_r.lo[pidx], pwdata, pstrb);
        end
        `PC_GRP_HI: begin
          st_nxt.hi[pidx] = merge(st_r.hi[pidx], pwdata, pstrb);
        end
        `PC_GRP_PAT: begin
          st_nxt.pat[pidx] = 8'(merge(32'(st_r.pat[pidx]), pwdata,
                                      pstrb));
        end
        default: begin
          st_nxt.enable = st_r.enable; // read-only or unmapped
        end
      endcase
    end
    // sticky error events, a new event beats a clear
    st_nxt.irq_st[`PC_IRQ_OVF_LSB +: 4] =
      st_nxt.irq_st[`PC_IRQ_OVF_LSB +: 4] | ovf;
    st_nxt.irq_st[`PC_IRQ_UDF_LSB +: 4] =
      st_nxt.irq_st[`PC_IRQ_UDF_LSB +: 4] | udf;
    st_nxt.irq_st[`PC_IRQ_CFG] = st_nxt.irq_st[`PC_IRQ_CFG] |
                                 (st_r.enable & (|cfg_bad));
    // interrupt only from error events, never from comparisons
    st_nxt.irq = |(st_nxt.irq_st & st_nxt.irq_mask); // see R06
    // comparison results into internal and external bits
    st_nxt.int_bits = pattern; // see R03
    st_nxt.out_line = pattern[0] | pattern[1] | pattern[2] |
                      pattern[3]; // see R05 see R11
    // indicators
    st_nxt.led.ready = st_r.enable; // see R07
    for (int i = 0; i < 4; i++) begin
      st_nxt.led.phase_a_indicator[i] = port_in[i].a; // see R08
      st_nxt.led.phase_b_indicator[i] = port_in[i].b; // see R08
      st_nxt.led.index_indicator[i] = port_in[i].z; // see R08
    end
    st_nxt.led.compare_output_line = st_nxt.out_line; // see R09
    st_nxt.led.err = (|cfg_bad) |
                     (|st_nxt.irq_st[`PC_IRQ_UDF_LSB +: 4]) |
                     (|st_nxt.irq_st[`PC_IRQ_OVF_LSB +: 4]); // see R10
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r.enable <= `PC_CTRL_RST;
      st_r.pcfg <= {4{`PC_PCFG_RST}};
      st_r.count <= {4{`PC_WORD_RST}};
      st_r.target <= {4{`PC_WORD_RST}};
      st_r.lo <= {4{`PC_COUNT_MAX}};
      st_r.hi <= {4{`PC_WORD_RST}};
      st_r.pat <= {4{`PC_PAT_RST}};
      st_r.irq_st <= `PC_IRQ_RST;
      st_r.irq_mask <= `PC_IRQ_RST;
      st_r.int_bits <= '0;
      st_r.out_line <= '0;
      st_r.led <= '0;
      st_r.irq <= 1'b0;
      st_r.pready <= 1'b0;
      st_r.pslverr <= 1'b0;
      st_r.prdata <= `PC_WORD_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from flops
  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign compare_output_line = st_r.out_line;
  assign leds = st_r.led;
  assign irq = st_r.irq;
endmodule : four_channel_pulse_counter
`default_nettype wire

// >>> hw/four_channel_pulse_counter_cfg.svh
`ifndef FOUR_CHANNEL_PULSE_COUNTER_CFG_SVH
`define FOUR_CHANNEL_PULSE_COUNTER_CFG_SVH
// apb byte addresses, word aligned
`define PC_ADDR_CTRL 8'h00
`define PC_ADDR_STATUS 8'h04
`define PC_ADDR_IRQ_STAT 8'h08
`define PC_ADDR_IRQ_MASK 8'h0C
`define PC_ADDR_OUT_BITS 8'h10
// register groups: group index in paddr[7:4], port in paddr[3:2] for groups 2 to 7
`define PC_GRP_MISC 4'h0
`define PC_GRP_OUTS 4'h1
`define PC_GRP_PCFG 4'h2
`define PC_GRP_COUNT 4'h3
`define PC_GRP_TARGET 4'h4
`define PC_GRP_LO 4'h5
`define PC_GRP_HI 4'h6
`define PC_GRP_PAT 4'h7
// port config fields
`define PC_CFG_MODE_LSB 0
`define PC_CFG_MULT_LSB 2
`define PC_CFG_CMP_EN 4
// pattern fields
`define PC_PAT_TGT_LSB 0
`define PC_PAT_RNG_LSB 4
// irq status fields
`define PC_IRQ_OVF_LSB 0
`define PC_IRQ_UDF_LSB 4
`define PC_IRQ_CFG 8
// status fields
`define PC_ST_READY 0
`define PC_ST_ERR 1
`define PC_ST_OUT_LSB 4
// reset values
`define PC_CTRL_RST 1'b0
`define PC_PCFG_RST 5'h00
`define PC_WORD_RST 32'h0000_0000
`define PC_PAT_RST 8'h00
`define PC_IRQ_RST 9'h000
`define PC_COUNT_MAX 32'hFFFF_FFFF
`define PC_COUNT_ONE 32'h0000_0001
// input rate limit and the sampling margin it leaves
`define PC_MAX_RATE_KHZ 500
`define PC_CLK_KHZ 25000
`define PC_CYC_PER_PULSE (`PC_CLK_KHZ / `PC_MAX_RATE_KHZ)
`endif

// >>> hw/four_channel_pulse_counter_pkg.sv
package four_channel_pulse_counter_pkg;
  // counting input mode, gray along diff -> updown -> pulse/dir
  typedef enum logic [1:0] {
    MODE_DIFF = 2'b00,
    MODE_UPDN = 2'b01,
    MODE_PDIR = 2'b11,
    MODE_BAD = 2'b10
  } mode_type;
  // differential multiplication
  typedef enum logic [1:0] {
    MULT_1X = 2'b00,
    MULT_2X = 2'b01,
    MULT_4X = 2'b11,
    MULT_BAD = 2'b10
  } mult_type;
  // one port's pins
  typedef struct packed {
    logic a; // phase a
    logic b; // phase b
    logic z; // phase z
  } phase_in_type;
  // one count step
  typedef struct packed {
    logic up; // count up pulse
    logic dn; // count down pulse
  } step_type;
  // front panel indicators
  typedef struct packed {
    logic ready; // ready to count
    logic err; // setup or count wrap error
    logic [3:0] phase_a_indicator; // per port a on
    logic [3:0] phase_b_indicator; // per port b on
    logic [3:0] index_indicator; // per port z on
    logic [3:0] compare_output_line; // external line on
  } led_type;
  // decoder state
  typedef struct packed {
    logic a; // previous a
    logic b; // previous b
    step_type step; // registered step
  } dec_state_type;
  // top state
  typedef struct packed {
    logic enable; // counting enabled
    logic [3:0][4:0] pcfg; // port config
    logic [3:0][31:0] count; // present count values
    logic [3:0][31:0] target; // target values
    logic [3:0][31:0] lo; // range low bounds
    logic [3:0][31:0] hi; // range high bounds
    logic [3:0][7:0] pat; // patterns
    logic [8:0] irq_st; // sticky events
    logic [8:0] irq_mask; // event mask
    logic [15:0] int_bits; // internal output bits
    logic [3:0] out_line; // external outputs
    led_type led; // indicators
    logic irq; // interrupt level
    logic pready; // apb ready
    logic pslverr; // apb error
    logic [31:0] prdata; // apb read data
  } top_state_type;
endpackage : four_channel_pulse_counter_pkg

// >>> hw/pulse_step_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module pulse_step_decoder (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, low
  input wire four_channel_pulse_counter_pkg::phase_in_type pins, // inputs
  input wire logic [1:0] mode, // input mode
  input wire logic [1:0] mult, // multiplication
  input wire logic enable, // counting allowed
  output four_channel_pulse_counter_pkg::step_type step // registered step
);
  four_channel_pulse_counter_pkg::dec_state_type st_r, st_nxt;
  logic ar, af, br, bf; // edges
  logic up1, dn1, up2, dn2, up4, dn4; // diff decodes

  // edge detection and mode decode
  always_comb begin
    ar = pins.a & ~st_r.a;
    af = ~pins.a & st_r.a;
    br = pins.b & ~st_r.b;
    bf = ~pins.b & st_r.b;
    up1 = ar & ~pins.b; // see R12
    dn1 = af & ~pins.b; // see R12
    up2 = up1 | (af & pins.b);
    dn2 = dn1 | (ar & pins.b);
    up4 = up2 | (br & pins.a) | (bf & ~pins.a);
    dn4 = dn2 | (br & ~pins.a) | (bf & pins.a);
    st_nxt = st_r;
    st_nxt.a = pins.a;
    st_nxt.b = pins.b;
    st_nxt.step = '0;
    unique case (mode) // see R02
      four_channel_pulse_counter_pkg::MODE_DIFF: begin
        unique case (mult) // see R12
          four_channel_pulse_counter_pkg::MULT_1X: begin
            st_nxt.step = {up1, dn1};
          end
          four_channel_pulse_counter_pkg::MULT_2X: begin
            st_nxt.step = {up2, dn2};
          end
          four_channel_pulse_counter_pkg::MULT_4X: begin
            st_nxt.step = {up4, dn4};
          end
          default: begin
            st_nxt.step = '0; // invalid multiplier
          end
        endcase
      end
      four_channel_pulse_counter_pkg::MODE_UPDN: begin
        // simultaneous up and down edges cancel
        st_nxt.step = (ar & br) ? 2'b00 : {ar, br};
      end
      four_channel_pulse_counter_pkg::MODE_PDIR: begin
        st_nxt.step = {ar & ~pins.b, ar & pins.b}; // b low counts up
      end
      four_channel_pulse_counter_pkg::MODE_BAD: begin
        st_nxt.step = '0;
      end
    endcase
    if (!enable) begin
      st_nxt.step = '0;
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign step = st_r.step;
endmodule : pulse_step_decoder
`default_nettype wire

// >>> hw/compare_pattern.sv
`timescale 1ns/1ps
`default_nettype none
module compare_pattern (
  input wire logic [31:0] count, // present count value
  input wire logic [31:0] target, // target value
  input wire logic [31:0] lo, // range low, inclusive
  input wire logic [31:0] hi, // range high, inclusive
  input wire logic [3:0] tgt_pat, // pattern on target match
  input wire logic [3:0] rng_pat, // pattern while in range
  input wire logic en, // comparison enabled
  output logic [3:0] pattern // selected bits
);
  // each result carries its own pattern, both may apply at once
  always_comb begin
    pattern = 4'h0;
    if (en && count == target) begin
      pattern = pattern | tgt_pat; // see R03 see R04
    end
    if (en && count >= lo && count <= hi) begin
      pattern = pattern | rng_pat; // see R03 see R04
    end
  end
endmodule : compare_pattern
`default_nettype wire

// >>> tb/four_channel_pulse_counter_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module pulse_counter_checker (
  input wire logic pclk, // clock
  input wire logic presetn, // reset
  input wire logic psel, // select
  input wire logic penable, // enable
  input wire logic pwrite, // write
  input wire logic [7:0] paddr, // address
  input wire logic [31:0] pwdata, // wdata
  input wire logic [3:0] pstrb, // lanes
  input wire logic [31:0] prdata, // rdata
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input wire four_channel_pulse_counter_pkg::phase_in_type [3:0]
    port_in, // pins
  input wire logic [3:0] compare_output_line, // lines
  input wire four_channel_pulse_counter_pkg::led_type leds, // indicators
  input wire logic irq // interrupt
);
  logic live_r; // past first edge
  logic [5:0] act_r; // recent activity
  logic [11:0] pin_r; // last pins
  // history of pin changes and writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin // cleared
      live_r <= 1'b0;
      act_r <= 6'h00;
      pin_r <= 12'h000;
    end else begin // shift in
      live_r <= 1'b1;
      pin_r <= port_in;
      act_r <= {act_r[4:0], (psel & penable & pwrite) | (pin_r != port_in)};
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_a_led;
    live_r |-> leds.phase_a_indicator ==
      $past({port_in[3].a, port_in[2].a, port_in[1].a, port_in[0].a});
  endproperty
  a_a_led: assert property (p_a_led) else $error("a led");
  property p_b_led;
    live_r |-> leds.phase_b_indicator ==
      $past({port_in[3].b, port_in[2].b, port_in[1].b, port_in[0].b});
  endproperty
  a_b_led: assert property (p_b_led) else $error("b led");
  property p_z_led;
    live_r |-> leds.index_indicator ==
      $past({port_in[3].z, port_in[2].z, port_in[1].z, port_in[0].z});
  endproperty
  a_z_led: assert property (p_z_led) else $error("z led");
  property p_out_led;
    live_r |-> leds.compare_output_line == compare_output_line;
  endproperty
  a_out_led: assert property (p_out_led) else $error("line led");
  property p_ready_led;
    (psel && penable && pready && pwrite && paddr == 8'h00 && pstrb[0])
      |-> ##2 leds.ready == $past(pwdata[0], 2);
  endproperty
  a_ready_led: assert property (p_ready_led) else $error("ready");
  property p_cmp_cause;
    $changed(compare_output_line) |-> |act_r;
  endproperty
  a_cmp_cause: assert property (p_cmp_cause) else $error("lines");
  property p_acc;
    psel && !penable |=> pready;
  endproperty
  a_acc: assert property (p_acc) else $error("no ready");
  property p_acc_cause;
    pready |-> $past(psel && !penable);
  endproperty
  a_acc_cause: assert property (p_acc_cause) else $error("stray ready");
  property p_err_ready;
    pslverr |-> pready;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("stray error");
  c_err: cover property (leds.err);
  c_lines: cover property ($rose(|compare_output_line));
  c_slverr: cover property (pslverr);
endmodule : pulse_counter_checker
bind four_channel_pulse_counter pulse_counter_checker chk_i (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
  .pslverr, .port_in, .compare_output_line, .leds, .irq);
`default_nettype wire

// >>> tb/pulse_source_model.sv
`timescale 1ns/1ps
`default_nettype none
module pulse_source_model (
  input wire logic pclk, // clock
  output var four_channel_pulse_counter_pkg::phase_in_type [3:0]
    port_in // encoder pins
);
  // all pins low at start
  initial port_in = 12'h000;
  // set one port's a and b, held hold cycles
  task automatic drive(input int p, input logic a, input logic b,
                       input int hold);
    @(posedge pclk);
    port_in[p].a <= a;
    port_in[p].b <= b;
    repeat (hold - 1) @(posedge pclk); // at least 2 cycles
  endtask : drive
  // index pin level
  task automatic index(input int p, input logic z);
    @(posedge pclk);
    port_in[p].z <= z;
  endtask : index
  // whole quadrature cycles, a leads b going up
  task automatic quad(input int p, input logic up, input int n,
                      input int hold);
    for (int i = 0; i < n; i++) begin
      drive(p, up, !up, hold);
      drive(p, 1'b1, 1'b1, hold);
      drive(p, !up, up, hold);
      drive(p, 1'b0, 1'b0, hold);
    end
  endtask : quad
endmodule : pulse_source_model
`default_nettype wire

// >>> tb/tb_four_channel_pulse_counter.sv
`include "four_channel_pulse_counter_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_four_channel_pulse_counter;
  logic pclk = 1'b0; // clock
  logic presetn = 1'b0; // reset
  logic psel = 1'b0; // select
  logic penable = 1'b0; // enable
  logic pwrite = 1'b0; // write
  logic [7:0] paddr = 8'h00; // address
  logic [31:0] pwdata = 32'h0; // wdata
  logic [3:0] pstrb = 4'h0; // lanes
  logic [31:0] prdata; // rdata
  logic pready; // ready
  logic pslverr; // error
  four_channel_pulse_counter_pkg::phase_in_type [3:0] port_in; // pins
  logic [3:0] compare_output_line; // lines
  four_channel_pulse_counter_pkg::led_type leds; // indicators
  logic irq; // interrupt
  int num_errors = 0; // mismatches
  int n_compared = 0; // comparisons
  int cycles = 0; // run length
  always #20 pclk = ~pclk;
  four_channel_pulse_counter uut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .port_in,
    .compare_output_line, .leds, .irq);
  pulse_source_model src (.pclk, .port_in);
  // hang guard
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      end_of_test();
    end
  end
  task automatic end_of_test;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer, held until ready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] r,
                     output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle count assumed: only the hang guard ends this wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, 4'hF, r, e);
    chk({31'h0, e}, 32'h0);
  endtask : wr
  // read after counts settle
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    repeat (3) @(posedge pclk);
    apb(1'b0, a, 32'h0, 4'h0, r, e);
    chk(r, exp);
  endtask : rd
  function automatic logic [7:0] pa(input logic [3:0] g, input int p);
    return {g, p[1:0], 2'b00};
  endfunction : pa
  // port config with compare on
  function automatic logic [31:0] pc(input logic [1:0] md, input logic [1:0] ml);
    return {27'h0, 1'b1, ml, md};
  endfunction : pc
  // reset values, bad address, enable lane
  task automatic t_regs;
    logic [31:0] r;
    logic e;
    chk({31'h0, leds.ready}, 32'h0);
    rd(pa(`PC_GRP_LO, 2), 32'hFFFF_FFFF);
    rd(pa(`PC_GRP_HI, 1), 32'h0);
    apb(1'b0, 8'hFC, 32'h0, 4'h0, r, e);
    chk({r[30:0], e}, 32'h1);
    apb(1'b1, `PC_ADDR_CTRL, 32'h1, 4'h0, r, e);
    rd(`PC_ADDR_STATUS, 32'h0);
    wr(`PC_ADDR_CTRL, 32'h1);
    rd(`PC_ADDR_STATUS, 32'h1);
    chk({31'h0, leds.ready}, 32'h1);
  endtask : t_regs
  // quadrature in 1x, 2x, 4x on three ports, slow and fast
  task automatic t_diff;
    logic [1:0] ml [3];
    int k [3];
    ml = '{four_channel_pulse_counter_pkg::MULT_1X,
      four_channel_pulse_counter_pkg::MULT_2X,
      four_channel_pulse_counter_pkg::MULT_4X};
    k = '{1, 2, 4};
    for (int p = 0; p < 3; p++) begin
      wr(pa(`PC_GRP_PCFG, p), pc(2'b00, ml[p]));
      src.quad(p, 1'b1, 3, p == 0 ? 50 : 2);
      rd(pa(`PC_GRP_COUNT, p), 32'(3 * k[p]));
      src.quad(p, 1'b0, 2, 2);
      rd(pa(`PC_GRP_COUNT, p), 32'(k[p]));
    end
  endtask : t_diff
  // up/down, pulse/direction, underflow and bad setup
  task automatic t_modes;
    logic [1:0] ud [8];
    logic [1:0] pd [5];
    ud = '{2'b10, 2'b00, 2'b10, 2'b00, 2'b11, 2'b00, 2'b01, 2'b00};
    pd = '{2'b01, 2'b11, 2'b01, 2'b11, 2'b00};
    wr(pa(`PC_GRP_PCFG, 3), pc(four_channel_pulse_counter_pkg::MODE_UPDN, 2'b00));
    foreach (ud[i]) src.drive(3, ud[i][1], ud[i][0], 2);
    rd(pa(`PC_GRP_COUNT, 3), 32'h1);
    wr(pa(`PC_GRP_PCFG, 3), pc(four_channel_pulse_counter_pkg::MODE_PDIR, 2'b00));
    foreach (pd[i]) src.drive(3, pd[i][1], pd[i][0], 2);
    rd(pa(`PC_GRP_COUNT, 3), 32'hFFFF_FFFF);
    chk({31'h0, leds.err}, 32'h1);
    chk({31'h0, irq}, 32'h0);
    rd(`PC_ADDR_IRQ_STAT, 32'h80);
    wr(`PC_ADDR_IRQ_MASK, 32'h80);
    rd(`PC_ADDR_IRQ_MASK, 32'h80);
    chk({31'h0, irq}, 32'h1);
    wr(`PC_ADDR_IRQ_STAT, 32'h80);
    rd(`PC_ADDR_STATUS, 32'h1);
    chk({31'h0, irq}, 32'h0);
    wr(pa(`PC_GRP_PCFG, 3), pc(four_channel_pulse_counter_pkg::MODE_BAD, 2'b00));
    rd(`PC_ADDR_STATUS, 32'h3);
    wr(pa(`PC_GRP_PCFG, 3), pc(2'b00, four_channel_pulse_counter_pkg::MULT_BAD));
    rd(`PC_ADDR_STATUS, 32'h3);
    wr(pa(`PC_GRP_PCFG, 3), pc(four_channel_pulse_counter_pkg::MODE_UPDN, 2'b00));
    rd(`PC_ADDR_STATUS, 32'h1);
    wr(`PC_ADDR_IRQ_STAT, 32'h1FF);
    rd(`PC_ADDR_IRQ_STAT, 32'h0);
  endtask : t_modes
  // target and range patterns merged on the lines
  task automatic t_compare;
    wr(`PC_ADDR_IRQ_MASK, 32'h1FF);
    wr(pa(`PC_GRP_TARGET, 0), 32'h5);
    wr(pa(`PC_GRP_PAT, 0), 32'h01);
    wr(pa(`PC_GRP_COUNT, 0), 32'h5);
    wr(pa(`PC_GRP_LO, 1), 32'h1);
    wr(pa(`PC_GRP_HI, 1), 32'h3);
    wr(pa(`PC_GRP_PAT, 1), 32'h40);
    wr(pa(`PC_GRP_COUNT, 1), 32'h3);
    wr(pa(`PC_GRP_TARGET, 2), 32'h4);
    wr(pa(`PC_GRP_PAT, 2), 32'h08);
    rd(`PC_ADDR_OUT_BITS, 32'h841);
    chk({28'h0, compare_output_line}, 32'hD);
    chk({28'h0, leds.compare_output_line}, 32'hD);
    chk({31'h0, irq}, 32'h0);
    wr(pa(`PC_GRP_COUNT, 1), 32'h4);
    rd(`PC_ADDR_STATUS, 32'h91);
    src.quad(0, 1'b1, 1, 2);
    rd(`PC_ADDR_STATUS, 32'h81);
    src.index(2, 1'b1);
    repeat (2) @(posedge pclk);
    chk({28'h0, leds.index_indicator}, 32'h4);
  endtask : t_compare
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_diff();
    t_modes();
    t_compare();
    end_of_test();
  end
endmodule : tb_four_channel_pulse_counter
`default_nettype wire
